// file: logic/sbd_defs.svh
`ifndef SBD_DEFS_SVH
`define SBD_DEFS_SVH
// register byte offsets
`define SBD_OFS_STATUS 8'h00
`define SBD_OFS_DATA 8'h04
`define SBD_OFS_CTRL 8'h08
`define SBD_OFS_IRQ_ST 8'h0c
`define SBD_OFS_IRQ_MASK 8'h10
// status bit positions
`define SBD_RX_FULL_BIT 7
`define SBD_TX_EMPTY_BIT 5
`define SBD_MODE_FAULT_FLAG_BIT 4
// reset values
`define SBD_DATA_RST 8'h00
`define SBD_CTRL_RST 4'h0
`define SBD_IRQ_RST 4'h0
// link timing: bus clock period and serial half period
`define SBD_CLK_NS 5
`define SBD_HALF_NS 20
`define SBD_HALF_CYC ((`SBD_HALF_NS + `SBD_CLK_NS - 1) / `SBD_CLK_NS)
// idle write reaches the shifter within this many bus cycles
`define SBD_IDLE_LOAD_CYC 2
// bus responses
`define SBD_RESP_OKAY 2'b00
`define SBD_RESP_SLVERR 2'b10
`endif

// file: logic/sbd_pkg.sv
package sbd_pkg;
   // control register one fields, bit 3 down to bit 0
   typedef struct packed {
      logic tx_irq_enable;
      logic master_select;
      logic fault_enable;
      logic select_output_enable;
   } sbd_ctrl_t;
   // sticky interrupt events, bit 3 down to bit 0
   typedef struct packed {
      logic overrun;
      logic mode_fault;
      logic tx_empty;
      logic rx_full;
   } sbd_irq_t;
   // synchronised link pins
   typedef struct packed {
      logic ss_n;
      logic miso;
      logic mosi;
      logic sclk;
   } sbd_pins_t;
   // shifter states
   typedef enum logic {SBD_IDLE, SBD_RUN} sbd_state_t;
endpackage

// file: logic/sbd_core.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sbd_defs.svh"
// ====================================================
// What this block does
// - transfer completion sets receive full flag
// - status read then data read clears it
// - tx empty high with room, cleared by write
// - data write ignored unless status seen empty
// - tx irq when empty and enabled
// - buffer-to-shifter move sets tx empty
// - idle write reaches shifter within two cycles
// - queued byte reloads after transfer ends
// - master with select low sets mode fault
// - fault input only master, enabled, no output
// - status read then control write clears fault
// - data reads receive, writes transmit buffer
// - master starts transfer on buffered write
// - unread receive buffer means overrun, discard
module sbd_core (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write channels
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read channels
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // serial link pins
   input wire sbd_pkg::sbd_pins_t pins,
   output logic sclk_drive,
   output logic sclk_drive_en,
   output logic mosi_drive,
   output logic mosi_drive_en,
   output logic miso_drive,
   output logic miso_drive_en,
   output logic ss_n_drive,
   output logic ss_n_drive_en,
   // interrupts
   output logic irq,
   output logic tx_irq
);
   import sbd_pkg::*;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ====================================================
   // pin synchronisers
   sbd_pins_t sync1_reg, sync2_reg, sync3_reg;
   logic sclk_rise, sclk_fall;

   // two flops per pin, third for edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 4'h8;
         sync2_reg <= 4'h8;
         sync3_reg <= 4'h8;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign sclk_rise = sync2_reg.sclk & ~sync3_reg.sclk;
   assign sclk_fall = ~sync2_reg.sclk & sync3_reg.sclk;

   // ====================================================
   // state declarations
   sbd_ctrl_t ctrl_reg;
   sbd_irq_t irq_st_reg, irq_mask_reg, irq_ev;
   sbd_state_t state_reg;
   logic [7:0] rx_data_reg, tx_buf_reg, shift_reg;
   logic [7:0] div_cnt_reg;
   logic [2:0] bit_cnt_reg;
   logic tx_full_reg, rx_full_reg, mode_fault_flag_reg;
   logic rx_arm_reg, tx_arm_reg, mode_fault_flag_arm_reg;
   logic sclk_reg, samp_reg;
   logic wr_go, rd_go, wr_ok, data_wr, data_wr_ok, ctrl_wr, mask_wr;
   logic stat_rd, data_rd, irqst_rd, rx_clr, mode_fault_flag_clr;
   logic mode_fault_flag_en, mode_fault_flag_ev, load, tick, rise_ev, fall_ev, done, overrun;
   logic [7:0] rx_byte, status_byte;
   logic [31:0] rd_val;
   logic rd_err;

   // ====================================================
   // bus handshakes
   assign wr_go = awvalid & wvalid & ~bvalid;
   assign awready = wr_go;
   assign wready = wr_go;
   assign rd_go = arvalid & ~rvalid;
   assign arready = rd_go;

   // write decode, low byte lane carries the data
   assign wr_ok = wr_go & wstrb[0];
   assign data_wr = wr_ok & (awaddr == `SBD_OFS_DATA);
   assign ctrl_wr = wr_ok & (awaddr == `SBD_OFS_CTRL);
   assign mask_wr = wr_ok & (awaddr == `SBD_OFS_IRQ_MASK);
   assign data_wr_ok = data_wr & tx_arm_reg;

   // read decode
   assign stat_rd = rd_go & (araddr == `SBD_OFS_STATUS);
   assign data_rd = rd_go & (araddr == `SBD_OFS_DATA);
   assign irqst_rd = rd_go & (araddr == `SBD_OFS_IRQ_ST);

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `SBD_RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         case (awaddr)
            `SBD_OFS_STATUS, `SBD_OFS_DATA, `SBD_OFS_CTRL,
            `SBD_OFS_IRQ_ST, `SBD_OFS_IRQ_MASK: bresp <= `SBD_RESP_OKAY;
            default: bresp <= `SBD_RESP_SLVERR;
         endcase
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // status byte image
   assign status_byte = {rx_full_reg, 1'b0, ~tx_full_reg, mode_fault_flag_reg, 4'h0};

   // read data mux
   always_comb begin
      rd_val = 32'h0;
      rd_err = 1'b0;
      case (araddr)
         `SBD_OFS_STATUS: rd_val = {24'h0, status_byte};
         `SBD_OFS_DATA: rd_val = {24'h0, rx_data_reg};
         `SBD_OFS_CTRL: rd_val = {28'h0, ctrl_reg};
         `SBD_OFS_IRQ_ST: rd_val = {28'h0, irq_st_reg};
         `SBD_OFS_IRQ_MASK: rd_val = {28'h0, irq_mask_reg};
         default: rd_err = 1'b1;
      endcase
   end

   // read response, data captured at address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `SBD_RESP_OKAY;
      end else if (rd_go) begin
         rvalid <= 1'b1;
         rdata <= rd_val;
         rresp <= rd_err ? `SBD_RESP_SLVERR : `SBD_RESP_OKAY;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ====================================================
   // control and mask registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `SBD_CTRL_RST;
         irq_mask_reg <= `SBD_IRQ_RST;
      end else begin
         if (ctrl_wr) begin
            ctrl_reg <= wdata[3:0];
         end
         if (mask_wr) begin
            irq_mask_reg <= wdata[3:0];
         end
      end
   end

   // ====================================================
   // shifter timing: master divider or slave pin edges
   assign tick = (state_reg == SBD_RUN) && (div_cnt_reg == 8'(`SBD_HALF_CYC - 1));
   assign rise_ev = ctrl_reg.master_select ? (tick & ~sclk_reg) : (sclk_rise & ~sync2_reg.ss_n);
   assign fall_ev = ctrl_reg.master_select ? (tick & sclk_reg) : (sclk_fall & ~sync2_reg.ss_n);
   assign done = (state_reg == SBD_RUN) & fall_ev & (bit_cnt_reg == 3'h7);
   assign rx_byte = {shift_reg[6:0], samp_reg};
   assign load = tx_full_reg & (state_reg == SBD_IDLE);

   // mode fault input qualification
   assign mode_fault_flag_en = ctrl_reg.master_select & ctrl_reg.fault_enable & ~ctrl_reg.select_output_enable;
   assign mode_fault_flag_ev = mode_fault_flag_en & ~sync2_reg.ss_n;

   // half period divider
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_reg <= 8'h00;
      end else if (state_reg != SBD_RUN || tick) begin
         div_cnt_reg <= 8'h00;
      end else begin
         div_cnt_reg <= div_cnt_reg + 8'h01;
      end
   end

   // shifter state machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= SBD_IDLE;
         bit_cnt_reg <= 3'h0;
         sclk_reg <= 1'b0;
         samp_reg <= 1'b0;
         shift_reg <= 8'h00;
      end else begin
         case (state_reg)
            SBD_IDLE: begin
               bit_cnt_reg <= 3'h0;
               sclk_reg <= 1'b0;
               if (load) begin
                  shift_reg <= tx_buf_reg;
               end
               if (ctrl_reg.master_select && load && !mode_fault_flag_ev) begin
                  state_reg <= SBD_RUN;
               end else if (!ctrl_reg.master_select && !sync2_reg.ss_n) begin
                  state_reg <= SBD_RUN;
               end
            end
            SBD_RUN: begin
               if (tick) begin
                  sclk_reg <= ~sclk_reg;
               end
               if (rise_ev) begin
                  samp_reg <= ctrl_reg.master_select ? sync2_reg.miso : sync2_reg.mosi;
               end
               if (fall_ev) begin
                  shift_reg <= rx_byte;
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
               end
               // abort on fault or deselect, finish after 8 bits
               if (done || mode_fault_flag_ev || (!ctrl_reg.master_select && sync2_reg.ss_n)) begin
                  state_reg <= SBD_IDLE;
                  sclk_reg <= 1'b0;
               end
            end
            default: state_reg <= SBD_IDLE;
         endcase
      end
   end

   // pin drivers
   assign sclk_drive = sclk_reg;
   assign sclk_drive_en = ctrl_reg.master_select;
   assign mosi_drive = shift_reg[7];
   assign mosi_drive_en = ctrl_reg.master_select;
   assign miso_drive = shift_reg[7];
   assign miso_drive_en = ~ctrl_reg.master_select & ~sync2_reg.ss_n;
   assign ss_n_drive = (state_reg != SBD_RUN);
   assign ss_n_drive_en = ctrl_reg.master_select & ctrl_reg.fault_enable & ctrl_reg.select_output_enable;

   // ====================================================
   // transmit buffer and empty flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_full_reg <= 1'b0;
         tx_buf_reg <= `SBD_DATA_RST;
      end else if (data_wr_ok) begin
         tx_full_reg <= 1'b1;
         tx_buf_reg <= wdata[7:0];
      end else if (load) begin
         tx_full_reg <= 1'b0;
      end
   end

   // tx arming by status read with empty set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_arm_reg <= 1'b0;
      end else if (stat_rd && !tx_full_reg) begin
         tx_arm_reg <= 1'b1;
      end else if (data_wr) begin
         tx_arm_reg <= 1'b0;
      end
   end

   assign tx_irq = ~tx_full_reg & ctrl_reg.tx_irq_enable;

   // ====================================================
   // receive buffer and full flag
   assign rx_clr = data_rd & rx_arm_reg;
   assign overrun = done & rx_full_reg & ~rx_clr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_full_reg <= 1'b0;
         rx_data_reg <= `SBD_DATA_RST;
      end else begin
         rx_full_reg <= done | (rx_full_reg & ~rx_clr);
         if (done && !overrun) begin
            rx_data_reg <= rx_byte;
         end
      end
   end

   // rx arming by status read with full set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_arm_reg <= 1'b0;
      end else if (stat_rd && rx_full_reg) begin
         rx_arm_reg <= 1'b1;
      end else if (rx_clr) begin
         rx_arm_reg <= 1'b0;
      end
   end

   // ====================================================
   // mode fault flag, set wins over clear
   assign mode_fault_flag_clr = ctrl_wr & mode_fault_flag_arm_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_fault_flag_reg <= 1'b0;
         mode_fault_flag_arm_reg <= 1'b0;
      end else begin
         mode_fault_flag_reg <= mode_fault_flag_ev | (mode_fault_flag_reg & ~mode_fault_flag_clr);
         if (stat_rd && mode_fault_flag_reg) begin
            mode_fault_flag_arm_reg <= 1'b1;
         end else if (ctrl_wr) begin
            mode_fault_flag_arm_reg <= 1'b0;
         end
      end
   end

   // ====================================================
   // sticky interrupt status, cleared by reading it
   assign irq_ev = '{overrun: overrun, mode_fault: mode_fault_flag_ev & ~mode_fault_flag_reg,
                     tx_empty: load, rx_full: done & ~overrun};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_st_reg <= `SBD_IRQ_RST;
      end else begin
         irq_st_reg <= (irq_st_reg & ~(irqst_rd ? irq_st_reg : 4'h0)) | irq_ev;
      end
   end

   assign irq = |(irq_st_reg & irq_mask_reg);

   // ====================================================
   // checks
   rx_set_a: assert property (done && !rx_full_reg |=> rx_full_reg && rx_data_reg == $past(rx_byte))
      else $error("completion did not set receive full");
   rx_keep_a: assert property (rx_full_reg && !(data_rd && rx_arm_reg) |=> rx_full_reg)
      else $error("receive full cleared without sequence");
   tx_ignore_a: assert property (data_wr && !tx_arm_reg |=> $stable(tx_buf_reg))
      else $error("unarmed data write changed buffer");
   tx_irq_a: assert property (ctrl_reg.tx_irq_enable && $fell(tx_full_reg) |-> tx_irq)
      else $error("transmit interrupt missing");
   idle_load_a: assert property (data_wr_ok && state_reg == SBD_IDLE && !tx_full_reg
      |-> ##[1:2] (!tx_full_reg && shift_reg == $past(wdata[7:0], 2)))
      else $error("idle write not moved to shifter in time");
   reload_a: assert property (done && tx_full_reg && ctrl_reg.master_select && !mode_fault_flag_en
      |-> ##2 (state_reg == SBD_RUN && !tx_full_reg))
      else $error("queued byte not reloaded");
   mode_fault_flag_set_a: assert property (mode_fault_flag_ev |=> mode_fault_flag_reg)
      else $error("mode fault not flagged");
   mode_fault_flag_off_a: assert property (!mode_fault_flag_en && !mode_fault_flag_reg |=> !mode_fault_flag_reg)
      else $error("mode fault set while input disabled");
   mode_fault_flag_clr_a: assert property (mode_fault_flag_reg && !mode_fault_flag_arm_reg && !$past(mode_fault_flag_ev) |=> mode_fault_flag_reg)
      else $error("mode fault cleared without status read");
   overrun_a: assert property (overrun |=> $stable(rx_data_reg) && rx_full_reg)
      else $error("overrun byte overwrote receive buffer");
endmodule // sbd_core

// file: test/sbd_peer.sv
`timescale 1ns/1ps
// ==========================================
// serial peer: mode 0 slave, msb first
module sbd_peer (
   // link wires
   input wire logic sclk,
   input wire logic mosi,
   input wire logic ss_n,
   output logic miso,
   // observation
   output logic [7:0] got,
   output int bits
);
   logic [7:0] sh;
   logic [7:0] rx;
   initial begin
      sh = 8'h3c;
      rx = 8'h00;
      got = 8'h3c;
      bits = 0;
   end
   // reply to each byte with the last byte received
   always @(negedge ss_n) begin
      sh = got;
   end
   // sample on rising sclk
   always @(posedge sclk) begin
      if (!ss_n) begin
         rx = {rx[6:0], mosi};
         bits = bits + 1;
         if (bits % 8 == 0) got = rx;
      end
   end
   // shift on falling sclk, reload after a whole byte
   always @(negedge sclk) begin
      if (!ss_n) sh = (bits % 8 == 0) ? got : {sh[6:0], 1'b0};
   end
   // released line shows the inverse of the last level
   assign miso = ss_n ? ~sh[7] : sh[7];
endmodule // sbd_peer

// file: test/spi_buffer_status_data_test.sv
`timescale 1ns/1ps
`include "sbd_defs.svh"
// ==========================================
// bench top
module spi_buffer_status_data_test;
   import sbd_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq, tx_irq, ext_ss_n, peer_miso, ext_sclk, ext_mosi;
   logic [7:0] awaddr, araddr, peer_got;
   logic [31:0] wdata, rdata, rd_val;
   logic [1:0] bresp, rresp, resp;
   logic sclk_drive, sclk_drive_en, mosi_drive, mosi_drive_en;
   logic miso_drive, miso_drive_en, ss_n_drive, ss_n_drive_en;
   sbd_pins_t pins;
   int peer_bits, num_errors, check_count, cyc;
   // wire levels from all parties
   assign pins.sclk = sclk_drive_en ? sclk_drive : ext_sclk;
   assign pins.mosi = mosi_drive_en ? mosi_drive : ext_mosi;
   assign pins.ss_n = ss_n_drive_en ? ss_n_drive : ext_ss_n;
   assign pins.miso = miso_drive_en ? miso_drive : peer_miso;
   sbd_core dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pins(pins), .sclk_drive(sclk_drive),
      .sclk_drive_en(sclk_drive_en), .mosi_drive(mosi_drive), .mosi_drive_en(mosi_drive_en),
      .miso_drive(miso_drive), .miso_drive_en(miso_drive_en), .ss_n_drive(ss_n_drive),
      .ss_n_drive_en(ss_n_drive_en), .irq(irq), .tx_irq(tx_irq));
   sbd_peer peer (.sclk(pins.sclk), .mosi(pins.mosi), .ss_n(pins.ss_n), .miso(peer_miso), .got(peer_got),
      .bits(peer_bits));
   // ==========================================
   // clock and hang guard
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         num_errors++;
         close_out();
      end
   end
   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %0t %s got %h expected %h", $time, what, g, e);
      end
   endtask
   // bready and rready stay high for the whole run; only the hang guard ends a wait
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
      end while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do begin
         @(posedge aclk);
      end while (bvalid !== 1'b1);
      resp = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
      end while (rvalid !== 1'b1);
      rd_val = rdata;
      resp = rresp;
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset_unarmed();
      chk(tx_irq, 1'b0, "tx irq");
      wr(`SBD_OFS_CTRL, 32'h7);
      wr(`SBD_OFS_DATA, 32'h5a);
      repeat (40) @(posedge aclk);
      chk(peer_bits, 0, "unarmed write");
      rd(`SBD_OFS_STATUS);
      chk(rd_val, 32'h20, "status reset");
      rd(`SBD_OFS_DATA);
      chk(rd_val, 32'h0, "data reset");
      rd(8'h14);
      chk(rd_val, 32'h0, "unmapped read data");
      chk(resp, `SBD_RESP_SLVERR, "unmapped read resp");
      wr(8'h14, 32'hff);
      chk(resp, `SBD_RESP_SLVERR, "unmapped write resp");
   endtask
   task automatic t_idle_xfer();
      int n;
      rd(`SBD_OFS_STATUS);
      wr(`SBD_OFS_DATA, 32'ha5);
      // shifter load lands one edge after the write response
      @(posedge aclk);
      rd(`SBD_OFS_STATUS);
      chk(rd_val, 32'h20, "empty again");
      n = 0;
      do begin
         rd(`SBD_OFS_STATUS);
         n++;
      end while (rd_val[7] !== 1'b1 && n < 60);
      chk(rd_val, 32'ha0, "rx full");
      chk(peer_got, 8'ha5, "byte sent");
      rd(`SBD_OFS_DATA);
      chk(rd_val, 32'h3c, "byte received");
      rd(`SBD_OFS_STATUS);
      chk(rd_val, 32'h20, "rx cleared");
   endtask
   task automatic t_queue_overrun();
      int n;
      rd(`SBD_OFS_IRQ_ST);
      wr(`SBD_OFS_IRQ_MASK, 32'h8);
      wr(`SBD_OFS_CTRL, 32'hf);
      chk(tx_irq, 1'b1, "tx irq on");
      rd(`SBD_OFS_STATUS);
      wr(`SBD_OFS_DATA, 32'h11);
      @(posedge aclk);
      rd(`SBD_OFS_STATUS);
      wr(`SBD_OFS_DATA, 32'h22);
      rd(`SBD_OFS_STATUS);
      chk(rd_val, 32'h00, "queued full");
      chk(tx_irq, 1'b0, "tx irq off");
      n = 0;
      while (peer_bits < 24 && n < 400) begin
         @(posedge aclk);
         n++;
      end
      repeat (12) @(posedge aclk);
      chk(peer_got, 8'h22, "queued byte sent");
      rd(`SBD_OFS_STATUS);
      chk(rd_val, 32'ha0, "both done");
      chk(irq, 1'b1, "overrun irq");
      rd(`SBD_OFS_DATA);
      chk(rd_val, 32'ha5, "second byte lost");
      rd(`SBD_OFS_IRQ_ST);
      chk(rd_val, 32'hb, "irq events");
      chk(irq, 1'b0, "irq cleared");
   endtask
   task automatic t_mode_fault();
      logic [3:0] no_fault [3] = '{4'h7, 4'h4, 4'h5};
      ext_ss_n <= 1'b0;
      foreach (no_fault[i]) begin
         wr(`SBD_OFS_CTRL, {28'h0, no_fault[i]});
         repeat (8) @(posedge aclk);
         rd(`SBD_OFS_STATUS);
         chk(rd_val[4], 1'b0, "no fault");
      end
      wr(`SBD_OFS_CTRL, 32'h6);
      repeat (8) @(posedge aclk);
      rd(`SBD_OFS_STATUS);
      chk(rd_val, 32'h30, "fault set");
      ext_ss_n <= 1'b1;
      repeat (8) @(posedge aclk);
      wr(`SBD_OFS_CTRL, 32'h6);
      rd(`SBD_OFS_STATUS);
      chk(rd_val, 32'h20, "fault cleared");
   endtask
   task automatic t_slave_xfer();
      logic [7:0] got, send;
      got = 8'h00;
      send = 8'h69;
      wr(`SBD_OFS_CTRL, 32'h0);
      rd(`SBD_OFS_STATUS);
      wr(`SBD_OFS_DATA, 32'h96);
      repeat (4) @(posedge aclk);
      ext_ss_n <= 1'b0;
      // far master: 64 ns link clock, mode 0, msb first, select held low for the whole frame
      for (int i = 7; i >= 0; i--) begin
         ext_mosi <= send[i];
         #32;
         ext_sclk <= 1'b1;
         got = {got[6:0], pins.miso};
         #32;
         ext_sclk <= 1'b0;
      end
      repeat (4) @(posedge aclk);
      ext_ss_n <= 1'b1;
      ext_mosi <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(got, 8'h96, "slave byte sent");
      rd(`SBD_OFS_STATUS);
      chk(rd_val, 32'ha0, "slave rx full");
      rd(`SBD_OFS_DATA);
      chk(rd_val, 32'h69, "slave byte received");
   endtask
   task automatic t_mid_reset();
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`SBD_OFS_DATA);
      chk(rd_val, 32'h0, "data after reset");
      rd(`SBD_OFS_STATUS);
      chk(rd_val, 32'h20, "status after reset");
      chk(tx_irq, 1'b0, "tx irq after reset");
   endtask
   // ==========================================
   // main sequence
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
      ext_sclk = 1'b0;
      ext_mosi = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      ext_ss_n = 1'b1;
      aresetn = 1'b0;
      num_errors = 0;
      check_count = 0;
      cyc = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_unarmed();
      t_idle_xfer();
      t_queue_overrun();
      t_mode_fault();
      t_slave_xfer();
      t_mid_reset();
      close_out();
   end
endmodule // spi_buffer_status_data_test
